// ==== pkg/hre_pkg.sv ====
// hre_pkg: constants shared by the serial channel event flag logic
package hre_pkg;

  // bit positions inside the main interrupt status word
  localparam int MAIN_W = 3;
  localparam int MAIN_POOL_FULL = 0;
  localparam int MAIN_MSG_END = 1;
  localparam int MAIN_POOL_READY = 2;

  // bit positions inside the extended interrupt status word
  localparam int EXT_W = 4;
  localparam int EXT_OVERFLOW = 0;
  localparam int EXT_FRAME_START = 1;
  localparam int EXT_MSG_REPEAT = 2;
  localparam int EXT_UNDERRUN = 3;

  // one accessible queue pool holds this many bytes
  localparam int POOL_BYTES = 32;
  localparam logic [4:0] RX_POOL_LAST = 5'h1f;
  // last delay count; frame start is reported on the second received byte after its cause
  localparam logic [1:0] FS_DELAY_LAST = 2'h1;
  // width of the transmit byte counter and of the programmed count
  localparam int TX_CNT_W = 12;
  localparam logic [11:0] TX_REPEAT_MIN = 12'h020;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [2:0] RST_SYNC = 3'h7;

  // transmit frame tracking states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_CLOSE = 2'b10,
    TX_WAIT_ACK = 2'b11
  } hre_tx_state_e;

endpackage : hre_pkg

// ==== verilog/hre_sync.sv ====
// hre_sync: three stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
`default_nettype none
module hre_sync
  import hre_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);

  logic [2:0] stage_q;

  // first stage feeds only the second; idle level of the pin is high
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stage_q <= RST_SYNC;
    end else begin
      stage_q <= {stage_q[1:0], i_pin};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_level <= 1'b1;
    end else if (stage_q[1] == stage_q[2]) begin
      o_level <= stage_q[2];
    end
  end

endmodule : hre_sync
`default_nettype wire

// ==== verilog/hre_flag_bank.sv ====
// hre_flag_bank: sticky event flags cleared by reading their status word
`timescale 1ns/1ps
`default_nettype none
module hre_flag_bank #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic i_clr,
  output logic [WIDTH-1:0] o_flag
);

  // a set in the clearing cycle wins, so no event is lost to a read
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= '0;
    end else begin
      o_flag <= i_set | (o_flag & {WIDTH{~i_clr}});
    end
  end

endmodule : hre_flag_bank
`default_nettype wire

// ==== verilog/hre_event_logic.sv ====
// hre_event_logic: receive and transmit event flags of one serial channel
// Operation
// RL1: cpu mode: pool full at 32 unfinished bytes
// RL2: cpu mode: message end after checksum, flag
// RL3: dma mode: message end after queue read out
// RL4: overflow when queue full at frame start
// RL5: frame start only with its enable set
// RL6: frame start two bytes after match/flag
// RL7: control, address, status valid at frame start
// RL8: pool ready when pool empty, also after reset; here only the transmitter reset command sets it, i_rst clears it
// RL9: cpu mode: pool ready repeatedly before message end
// RL10: pool ready after transparent frame closes
// RL11: auto mode: pool ready on positive acknowledge
// RL12: auto mode: repeat on negative acknowledge
// RL13: bus: repeat on collision after byte 32
// RL14: point-to-point: repeat on clear-to-send loss
// RL15: underrun when queue and shifter empty, no end
// RL16: end from command, or count match in dma
// RL17: flags split over main and extended status
// RL18: interrupt low until all sources read clear
// RL19: main status bits individually maskable
// RL20: cpu mode after reset, dma via count bit
// RL21: flags sticky until cleared
`timescale 1ns/1ps
`default_nettype none
module hre_event_logic
  import hre_pkg::*;
#(
  parameter int TX_COUNT_W = TX_CNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // configuration bits
  input wire logic i_dma_mode,
  input wire logic i_frame_start_irq_enable,
  input wire logic i_auto_mode,
  input wire logic i_addr_recog_mode,
  input wire logic i_bus_config,
  input wire logic [MAIN_W-1:0] i_main_mask,
  // receive datapath events
  input wire logic i_rx_byte_stored,
  input wire logic i_rx_frame_end,
  input wire logic i_rx_queue_full,
  input wire logic i_rx_queue_empty,
  input wire logic i_rx_opening_flag,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_byte_received,
  input wire logic [7:0] i_rx_control_field,
  input wire logic [7:0] i_rx_address,
  input wire logic [3:0] i_rx_status,
  // transmit commands and datapath events
  input wire logic i_tx_reset_cmd,
  input wire logic i_tx_transparent_frame_cmd,
  input wire logic i_tx_info_frame_cmd,
  input wire logic i_tx_message_end_cmd,
  input wire logic i_tx_pool_drained,
  input wire logic i_tx_closing_done,
  input wire logic i_tx_byte_shifted,
  input wire logic i_tx_queue_empty,
  input wire logic i_tx_shift_idle,
  input wire logic i_ack_positive,
  input wire logic i_ack_negative,
  input wire logic i_collision,
  input wire logic i_cts_pin,
  input wire logic [TX_COUNT_W-1:0] i_tx_count,
  // status reads
  input wire logic i_main_status_rd,
  input wire logic i_ext_status_rd,
  // outputs
  output logic [MAIN_W-1:0] o_main_irq_status,
  output logic [EXT_W-1:0] o_extended_irq_status,
  output logic [7:0] o_rx_control_field_reg,
  output logic [7:0] o_rx_address_first,
  output logic [3:0] o_rx_status_reg,
  output logic o_int_n
);

  logic [4:0] rx_pool_cnt_q;
  logic rx_dma_pend_q;
  logic fs_arm_q;
  logic [1:0] fs_cnt_q;
  logic cts_level;
  logic cts_prev_q;
  hre_tx_state_e tx_state_q;
  logic tx_info_q;
  logic eom_cmd_q;
  logic [TX_COUNT_W-1:0] tx_sent_q;
  logic pool_full_evt;
  logic msg_end_evt;
  logic ovf_evt;
  logic fs_evt;
  logic fs_cause;
  logic pool_ready_evt;
  logic repeat_evt;
  logic underrun_evt;
  logic eom_now;
  logic tx_active;
  logic cts_fall;
  logic [MAIN_W-1:0] main_set;
  logic [EXT_W-1:0] ext_set;

  // clear-to-send arrives from a pin, so it is synchronised first
  hre_sync u_cts_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_cts_pin),
    .o_level(cts_level)
  );

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cts_prev_q <= 1'b1;
    end else begin
      cts_prev_q <= cts_level;
    end
  end
  assign cts_fall = cts_prev_q & ~cts_level;

  // ---------------- receive side ----------------

  // bytes of the open message in the current pool; a frame end restarts it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_pool_cnt_q <= '0;
    end else if (i_rx_frame_end) begin
      rx_pool_cnt_q <= '0;
    end else if (i_rx_byte_stored) begin
      rx_pool_cnt_q <= rx_pool_cnt_q + 5'h01;
    end
  end

  // RL1: pool full event
  // RL20: dma input selects mode, low means cpu mode
  assign pool_full_evt = ~i_dma_mode & i_rx_byte_stored & ~i_rx_frame_end
                         & (rx_pool_cnt_q == RX_POOL_LAST);

  // RL3: pending until drained
  // dma mode waits for the controller to empty the queue after the end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_dma_pend_q <= 1'b0;
    end else if (i_rx_frame_end & i_dma_mode) begin
      rx_dma_pend_q <= 1'b1;
    end else if (i_rx_queue_empty | ~i_dma_mode) begin
      rx_dma_pend_q <= 1'b0;
    end
  end

  // RL2: cpu message end
  // RL3: dma message end
  assign msg_end_evt = (~i_dma_mode & i_rx_frame_end)
                       | (rx_dma_pend_q & i_dma_mode & i_rx_queue_empty);

  // RL4: overflow on full queue
  assign ovf_evt = i_rx_queue_full & i_rx_opening_flag;

  // RL6: frame start cause
  assign fs_cause = i_addr_recog_mode ? i_rx_addr_match : i_rx_opening_flag;

  // RL6: two byte delay
  // a new cause restarts the delay, so back to back frames report once each
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fs_arm_q <= 1'b0;
      fs_cnt_q <= '0;
    end else if (fs_cause) begin
      fs_arm_q <= 1'b1;
      fs_cnt_q <= '0;
    end else if (fs_arm_q & i_rx_byte_received) begin
      fs_arm_q <= (fs_cnt_q != FS_DELAY_LAST);
      fs_cnt_q <= fs_cnt_q + 2'h1;
    end
  end

  // RL5: gated by enable
  assign fs_evt = fs_arm_q & i_rx_byte_received & ~fs_cause
                  & (fs_cnt_q == FS_DELAY_LAST) & i_frame_start_irq_enable;

  // RL7: capture with the event
  // captured on the same edge the flag sets, so a read after it is valid
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rx_control_field_reg <= RST_BYTE;
      o_rx_address_first <= RST_BYTE;
      o_rx_status_reg <= RST_NIB;
    end else if (fs_arm_q & i_rx_byte_received & ~fs_cause
                 & (fs_cnt_q == FS_DELAY_LAST)) begin
      o_rx_control_field_reg <= i_rx_control_field;
      o_rx_address_first <= i_rx_address;
      o_rx_status_reg <= i_rx_status;
    end
  end

  // ---------------- transmit side ----------------

  // RL16: end of message source
  assign eom_now = i_dma_mode ? (tx_sent_q == i_tx_count) : eom_cmd_q;
  assign tx_active = (tx_state_q == TX_SEND) | (tx_state_q == TX_CLOSE);

  // frame progress; a transmitter reset aborts whatever is in flight
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_state_q <= TX_IDLE;
    end else if (i_tx_reset_cmd) begin
      tx_state_q <= TX_IDLE;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          if (i_tx_transparent_frame_cmd | i_tx_info_frame_cmd) begin
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (underrun_evt) begin
            tx_state_q <= TX_IDLE;
          end else if (eom_now) begin
            tx_state_q <= TX_CLOSE;
          end
        end
        TX_CLOSE: begin
          if (i_tx_closing_done) begin
            tx_state_q <= (i_auto_mode & tx_info_q) ? TX_WAIT_ACK : TX_IDLE;
          end
        end
        TX_WAIT_ACK: begin
          if (i_ack_positive | i_ack_negative) begin
            tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // frame kind, end command latch and bytes shifted out
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_info_q <= 1'b0;
      eom_cmd_q <= 1'b0;
      tx_sent_q <= '0;
    end else if (i_tx_reset_cmd) begin
      tx_info_q <= 1'b0;
      eom_cmd_q <= 1'b0;
      tx_sent_q <= '0;
    end else if (tx_state_q == TX_IDLE) begin
      tx_info_q <= i_tx_info_frame_cmd;
      eom_cmd_q <= 1'b0;
      tx_sent_q <= '0;
    end else begin
      if (i_tx_message_end_cmd) begin
        eom_cmd_q <= 1'b1;
      end
      if (tx_active & i_tx_byte_shifted & (tx_sent_q != '1)) begin
        tx_sent_q <= tx_sent_q + TX_COUNT_W'(1);
      end
    end
  end

  // RL8: reset command
  // RL9: each drained pool
  // RL10: after closing flag
  // RL11: positive acknowledge
  assign pool_ready_evt = i_tx_reset_cmd
      | (~i_dma_mode & (tx_state_q == TX_SEND) & ~eom_now & i_tx_pool_drained)
      | ((tx_state_q == TX_CLOSE) & i_tx_closing_done & ~(i_auto_mode & tx_info_q))
      | (i_auto_mode & i_ack_positive);

  // RL12: negative acknowledge
  // RL13: bus collision
  // RL14: clear-to-send lost
  assign repeat_evt = (i_auto_mode & i_ack_negative)
      | (tx_active & (tx_sent_q >= TX_REPEAT_MIN)
         & (i_bus_config ? i_collision : cts_fall));

  // RL15: underrun detect
  assign underrun_evt = (tx_state_q == TX_SEND) & i_tx_queue_empty
                        & i_tx_shift_idle & ~eom_now & ~i_tx_reset_cmd;

  // ---------------- status words and interrupt ----------------

  // RL17: main and extended split
  always_comb begin
    main_set = '0;
    ext_set = '0;
    main_set[MAIN_POOL_FULL] = pool_full_evt;
    main_set[MAIN_MSG_END] = msg_end_evt;
    main_set[MAIN_POOL_READY] = pool_ready_evt;
    ext_set[EXT_OVERFLOW] = ovf_evt;
    ext_set[EXT_FRAME_START] = fs_evt;
    ext_set[EXT_MSG_REPEAT] = repeat_evt;
    ext_set[EXT_UNDERRUN] = underrun_evt;
  end

  // RL21: sticky main flags
  hre_flag_bank #(
    .WIDTH(MAIN_W)
  ) u_main_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_set(main_set),
    .i_clr(i_main_status_rd),
    .o_flag(o_main_irq_status)
  );

  // RL21: sticky extended flags
  hre_flag_bank #(
    .WIDTH(EXT_W)
  ) u_ext_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_set(ext_set),
    .i_clr(i_ext_status_rd),
    .o_flag(o_extended_irq_status)
  );

  // RL18: line low while pending
  // RL19: mask hides main bits
  // masked bits still latch, only the line ignores them
  assign o_int_n = ~(|(o_main_irq_status & ~i_main_mask) | (|o_extended_irq_status));

  // ---------------- checks ----------------

  sequence s_ovf_cause;
    i_rx_queue_full && i_rx_opening_flag;
  endsequence

  sequence s_tx_reset;
    i_tx_reset_cmd;
  endsequence

  sequence s_rx_end_cpu;
    !i_dma_mode && i_rx_frame_end;
  endsequence

  a_overflow_set: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL4
    s_ovf_cause |=> o_extended_irq_status[EXT_OVERFLOW])
    else $error("overflow flag not raised");

  a_pool_ready_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL8
    s_tx_reset |=> o_main_irq_status[MAIN_POOL_READY] && tx_state_q == TX_IDLE)
    else $error("pool ready missing after transmitter reset");

  a_msg_end_cpu: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL2
    s_rx_end_cpu |=> o_main_irq_status[MAIN_MSG_END])
    else $error("message end missing in cpu mode");

  a_pool_full_dma: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL1
    $rose(o_main_irq_status[MAIN_POOL_FULL]) |-> !$past(i_dma_mode)
                                                  && $past(rx_pool_cnt_q) == RX_POOL_LAST)
    else $error("pool full raised at wrong count or in dma mode");

  a_msg_end_dma: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL3
    (i_dma_mode && i_rx_frame_end && !i_rx_queue_empty) ##1
      (i_dma_mode && !i_rx_queue_empty && !i_rx_frame_end && !i_main_status_rd
       && !o_main_irq_status[MAIN_MSG_END])
    |=> !o_main_irq_status[MAIN_MSG_END])
    else $error("dma message end raised before queue drained");

  a_fs_enable_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL5
    $rose(o_extended_irq_status[EXT_FRAME_START]) |-> $past(i_frame_start_irq_enable))
    else $error("frame start raised while disabled");

  a_fs_capture: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL7
    $rose(o_extended_irq_status[EXT_FRAME_START])
      |-> o_rx_address_first == $past(i_rx_address)
          && o_rx_status_reg == $past(i_rx_status))
    else $error("frame start registers not captured with flag");

  a_underrun_set: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL15
    (tx_state_q == TX_SEND && i_tx_queue_empty && i_tx_shift_idle && !eom_now
     && !i_tx_reset_cmd) |=> o_extended_irq_status[EXT_UNDERRUN] && tx_state_q == TX_IDLE)
    else $error("underrun not flagged");

  a_repeat_early: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL13
    (tx_active && i_bus_config && i_collision && !i_auto_mode
     && tx_sent_q < TX_REPEAT_MIN && !o_extended_irq_status[EXT_MSG_REPEAT])
    |=> !o_extended_irq_status[EXT_MSG_REPEAT])
    else $error("repeat raised before byte 32");

  a_int_line: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL18
    (|o_extended_irq_status) |-> !o_int_n)
    else $error("interrupt line released with pending source");

  a_mask_hides: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL19
    (o_extended_irq_status == '0 && (o_main_irq_status & ~i_main_mask) == '0) |-> o_int_n)
    else $error("masked source drives interrupt line");

  a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL21
    (o_extended_irq_status[EXT_OVERFLOW] && !i_ext_status_rd)
      |=> o_extended_irq_status[EXT_OVERFLOW])
    else $error("flag dropped without a read");

endmodule : hre_event_logic
`default_nettype wire

// ==== testbench/hre_host_model.sv ====
// hre_host_model: host that answers the interrupt line by reading both status words
`timescale 1ns/1ps
`default_nettype none
module hre_host_model
  import hre_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_int_n,
  input wire logic [MAIN_W-1:0] i_main,
  input wire logic [EXT_W-1:0] i_ext,
  output logic o_rd,
  output logic [MAIN_W-1:0] o_main_seen,
  output logic [EXT_W-1:0] o_ext_seen
);
  // clear by read
  // one read pulse at a time, so the line is looked at again only after the clear lands
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rd <= 1'h0;
    end else begin
      o_rd <= i_enable && !i_int_n && !o_rd;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_main_seen <= '0;
      o_ext_seen <= '0;
    end else if (o_rd) begin
      o_main_seen <= i_main;
      o_ext_seen <= i_ext;
    end
  end
endmodule : hre_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: self-checking bench for the receive and transmit event flags
`timescale 1ns/1ps
`default_nettype none
module tb
  import hre_pkg::*;
;
  localparam logic [2:0] PF = 3'h1 << MAIN_POOL_FULL;
  localparam logic [2:0] ME = 3'h1 << MAIN_MSG_END;
  localparam logic [2:0] PR = 3'h1 << MAIN_POOL_READY;
  localparam logic [3:0] OV = 4'h1 << EXT_OVERFLOW;
  localparam logic [3:0] FS = 4'h1 << EXT_FRAME_START;
  localparam logic [3:0] RP = 4'h1 << EXT_MSG_REPEAT;
  localparam logic [3:0] UR = 4'h1 << EXT_UNDERRUN;
  logic i_clk_sys, i_rst, i_dma_mode, i_frame_start_irq_enable, i_auto_mode, i_addr_recog_mode;
  logic i_bus_config, i_rx_byte_stored, i_rx_frame_end, i_rx_queue_full, i_rx_queue_empty;
  logic i_rx_opening_flag, i_rx_addr_match, i_rx_byte_received, i_tx_reset_cmd;
  logic i_tx_transparent_frame_cmd, i_tx_info_frame_cmd, i_tx_message_end_cmd;
  logic i_tx_pool_drained, i_tx_closing_done, i_tx_byte_shifted, i_tx_queue_empty;
  logic i_tx_shift_idle, i_ack_positive, i_ack_negative, i_collision, i_cts_pin;
  logic rd, hen, o_int_n;
  logic [2:0] i_main_mask, o_main_irq_status, main_seen;
  logic [3:0] o_extended_irq_status, ext_seen, i_rx_status, o_rx_status_reg;
  logic [7:0] i_rx_control_field, i_rx_address, o_rx_control_field_reg, o_rx_address_first;
  logic [TX_CNT_W-1:0] i_tx_count;
  int err_count, cmp_count;

  hre_event_logic i_dut (
    .i_clk_sys, .i_rst, .i_dma_mode, .i_frame_start_irq_enable, .i_auto_mode,
    .i_addr_recog_mode, .i_bus_config, .i_main_mask, .i_rx_byte_stored, .i_rx_frame_end,
    .i_rx_queue_full, .i_rx_queue_empty, .i_rx_opening_flag, .i_rx_addr_match,
    .i_rx_byte_received, .i_rx_control_field, .i_rx_address, .i_rx_status, .i_tx_reset_cmd,
    .i_tx_transparent_frame_cmd, .i_tx_info_frame_cmd, .i_tx_message_end_cmd,
    .i_tx_pool_drained, .i_tx_closing_done, .i_tx_byte_shifted, .i_tx_queue_empty,
    .i_tx_shift_idle, .i_ack_positive, .i_ack_negative, .i_collision, .i_cts_pin,
    .i_tx_count, .i_main_status_rd(rd), .i_ext_status_rd(rd), .o_main_irq_status,
    .o_extended_irq_status, .o_rx_control_field_reg, .o_rx_address_first,
    .o_rx_status_reg, .o_int_n
  );
  hre_host_model i_host (
    .i_clk_sys, .i_rst, .i_enable(hen), .i_int_n(o_int_n), .i_main(o_main_irq_status),
    .i_ext(o_extended_irq_status), .o_rd(rd), .o_main_seen(main_seen), .o_ext_seen(ext_seen)
  );

  // 125 MHz system clock
  initial begin
    i_clk_sys = 1'h0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // inputs always move 1 ns after the edge, never on it
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc
  // held high for n edges gives n events in a row without a re-arm glitch
  task automatic pl(ref logic s, input int n = 1);
    s = 1'h1;
    cyc(n);
    s = 1'h0;
  endtask : pl
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // both words plus the line, whose level follows from flags and mask
  task automatic ck(input string s, input logic [2:0] m, input logic [3:0] e);
    chk({s, " main"}, o_main_irq_status, m);
    chk({s, " ext"}, o_extended_irq_status, e);
    chk({s, " int_n"}, o_int_n, !((m & ~i_main_mask) != 3'h0 || e != 4'h0));
  endtask : ck
  // host services the line; bounded so a stuck line cannot hang the run
  task automatic clr();
    hen = 1'h1;
    for (int i = 0; i < 8 && (o_int_n !== 1'h1 || rd !== 1'h0); i++) cyc(1);
    hen = 1'h0;
    ck("cleared", 3'h0, 4'h0);
  endtask : clr
  task automatic txr();
    pl(i_tx_reset_cmd);
    ck("tx reset", PR, 4'h0);
    clr();
  endtask : txr

  task automatic t_rx_cpu();
    pl(i_rx_byte_stored, 31);
    ck("31 bytes", 3'h0, 4'h0);
    cyc(1);
    pl(i_rx_byte_stored);
    ck("32 bytes", PF, 4'h0);
    cyc(3);
    ck("sticky", PF, 4'h0);
    clr();
    chk("host main", main_seen, PF);
    pl(i_rx_byte_stored, 31);
    cyc(1);
    i_rx_frame_end = 1'h1;
    pl(i_rx_byte_stored);
    i_rx_frame_end = 1'h0;
    ck("end on 32nd", ME, 4'h0);
    clr();
    $display("t_rx_cpu done");
  endtask : t_rx_cpu

  task automatic t_rx_dma();
    i_dma_mode = 1'h1;
    pl(i_rx_byte_stored, 32);
    pl(i_rx_frame_end);
    cyc(2);
    ck("dma unread", 3'h0, 4'h0);
    i_rx_queue_empty = 1'h1;
    cyc(1);
    ck("dma read out", ME, 4'h0);
    i_rx_queue_empty = 1'h0;
    i_dma_mode = 1'h0;
    clr();
    $display("t_rx_dma done");
  endtask : t_rx_dma

  task automatic t_rx_start();
    i_rx_queue_full = 1'h1;
    pl(i_rx_opening_flag);
    ck("overflow", 3'h0, OV);
    i_rx_queue_full = 1'h0;
    pl(i_rx_byte_received, 2);
    ck("start disabled", 3'h0, OV);
    clr();
    chk("host ext", ext_seen, OV);
    i_frame_start_irq_enable = 1'h1;
    for (int m = 0; m < 2; m++) begin
      i_addr_recog_mode = m[0];
      if (m == 1) pl(i_rx_opening_flag); else pl(i_rx_addr_match);
      pl(i_rx_byte_received, 2);
      ck("wrong cause", 3'h0, 4'h0);
      if (m == 1) pl(i_rx_addr_match); else pl(i_rx_opening_flag);
      pl(i_rx_byte_received);
      ck("one byte", 3'h0, 4'h0);
      cyc(1);
      // fresh data only before the second byte, so an early capture shows
      i_rx_control_field = 8'ha0 | m[7:0];
      i_rx_address = 8'h50 | m[7:0];
      i_rx_status = 4'h9 ^ m[3:0];
      pl(i_rx_byte_received);
      ck("two bytes", 3'h0, FS);
      chk("ctl", o_rx_control_field_reg, i_rx_control_field);
      chk("addr", o_rx_address_first, i_rx_address);
      chk("stat", o_rx_status_reg, i_rx_status);
      clr();
    end
    i_frame_start_irq_enable = 1'h0;
    $display("t_rx_start done");
  endtask : t_rx_start

  task automatic t_tx_cpu();
    i_main_mask = PR;
    pl(i_tx_reset_cmd);
    ck("masked", PR, 4'h0);
    i_main_mask = 3'h0;
    cyc(1);
    ck("unmasked", PR, 4'h0);
    clr();
    pl(i_tx_transparent_frame_cmd);
    for (int k = 0; k < 2; k++) begin
      pl(i_tx_pool_drained);
      ck("pool drained", PR, 4'h0);
      clr();
    end
    pl(i_tx_message_end_cmd);
    pl(i_tx_pool_drained);
    {i_tx_queue_empty, i_tx_shift_idle} = 2'h3;
    cyc(2);
    ck("ended frame", 3'h0, 4'h0);
    pl(i_tx_closing_done);
    ck("closed", PR, 4'h0);
    clr();
    pl(i_tx_transparent_frame_cmd);
    cyc(1);
    ck("underrun", 3'h0, UR);
    {i_tx_queue_empty, i_tx_shift_idle} = 2'h0;
    clr();
    $display("t_tx_cpu done");
  endtask : t_tx_cpu

  task automatic t_tx_dma();
    i_dma_mode = 1'h1;
    i_tx_count = 12'h003;
    for (int n = 3; n >= 2; n--) begin
      pl(i_tx_transparent_frame_cmd);
      pl(i_tx_byte_shifted, n);
      {i_tx_queue_empty, i_tx_shift_idle} = 2'h3;
      cyc(2);
      ck("dma count", 3'h0, (n == 2) ? UR : 4'h0);
      {i_tx_queue_empty, i_tx_shift_idle} = 2'h0;
      if (n == 2) clr();
      txr();
    end
    i_dma_mode = 1'h0;
    $display("t_tx_dma done");
  endtask : t_tx_dma

  task automatic t_auto();
    i_auto_mode = 1'h1;
    pl(i_tx_info_frame_cmd);
    pl(i_tx_message_end_cmd);
    // one edge for the end mark to move the frame into closing
    cyc(1);
    pl(i_tx_closing_done);
    ck("await ack", 3'h0, 4'h0);
    pl(i_ack_positive);
    ck("ack", PR, 4'h0);
    clr();
    pl(i_tx_info_frame_cmd);
    pl(i_tx_message_end_cmd);
    cyc(1);
    pl(i_tx_closing_done);
    pl(i_ack_negative);
    ck("nak", 3'h0, RP);
    clr();
    txr();
    i_auto_mode = 1'h0;
    $display("t_auto done");
  endtask : t_auto

  // bus loses to a collision, point-to-point to clear-to-send withdrawn
  task automatic t_repeat();
    for (int b = 1; b >= 0; b--) begin
      i_bus_config = b[0];
      pl(i_tx_transparent_frame_cmd);
      for (int j = 31; j <= 32; j++) begin
        if (j == 32) pl(i_tx_byte_shifted); else pl(i_tx_byte_shifted, 31);
        if (b == 1) pl(i_collision); else i_cts_pin = 1'h0;
        cyc(8);
        ck("repeat", 3'h0, (j == 32) ? RP : 4'h0);
        i_cts_pin = 1'h1;
        cyc(8);
      end
      clr();
      txr();
    end
    $display("t_repeat done");
  endtask : t_repeat

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_count++;
    summarize();
  end

  initial begin
    {i_dma_mode, i_frame_start_irq_enable, i_auto_mode, i_addr_recog_mode, i_bus_config,
     i_rx_byte_stored, i_rx_frame_end, i_rx_queue_full, i_rx_queue_empty, i_rx_opening_flag,
     i_rx_addr_match, i_rx_byte_received, i_tx_reset_cmd, i_tx_transparent_frame_cmd,
     i_tx_info_frame_cmd, i_tx_message_end_cmd, i_tx_pool_drained, i_tx_closing_done,
     i_tx_byte_shifted, i_tx_queue_empty, i_tx_shift_idle, i_ack_positive, i_ack_negative,
     i_collision, hen, i_main_mask, i_rx_status, i_rx_control_field, i_rx_address,
     i_tx_count} = '0;
    i_cts_pin = 1'h1;
    i_rst = 1'h1;
    cyc(5);
    i_rst = 1'h0;
    ck("reset", 3'h0, 4'h0);
    t_rx_cpu();
    t_rx_dma();
    t_rx_start();
    t_tx_cpu();
    t_tx_dma();
    t_auto();
    t_repeat();
    summarize();
  end
endmodule : tb
`default_nettype wire
